// File: rtl/sff_pkg.sv
`default_nettype none
package sff_pkg;

    // ------------------------------------------------------------
    // spi commands
    // ------------------------------------------------------------
    localparam logic [7:0] SFF_CMD_FAST_READ = 8'h0b;
    localparam logic [7:0] SFF_CMD_EN_ADDR32 = 8'hb7;

    // ------------------------------------------------------------
    // field sizes and counts
    // ------------------------------------------------------------
    localparam int SFF_CMD_BITS    = 8;
    localparam int SFF_DUMMY_BITS  = 8;
    localparam int SFF_ADDR24_BITS = 24;
    localparam int SFF_ADDR32_BITS = 32;
    // read data is sampled this many clk cycles after the launching edge
    localparam int SFF_RX_DELAY    = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic SFF_CS_N_RST  = 1'b1;
    localparam logic SFF_SCK_RST   = 1'b0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        addr32;
        logic [31:0] addr;
        logic [15:0] len;
    } sff_req_t;

    typedef struct packed {
        logic       sck;
        logic       cs_n;
        logic       mosi;
    } sff_spi_out_t;

    typedef enum logic [2:0] {
        SFF_IDLE,
        SFF_EN32,
        SFF_GAP,
        SFF_CMD,
        SFF_ADDR,
        SFF_DUMMY,
        SFF_DATA,
        SFF_DONE
    } sff_state_t;

endpackage : sff_pkg
`default_nettype wire

// File: rtl/sff_sync.sv
`default_nettype none
module sff_sync
    import sff_pkg::*;
(
    // clock
    input  wire logic clk,
    input  wire logic ce,
    input  wire logic srst,
    // data
    input  wire logic d,
    output var  logic q
);
    logic meta_r;
    logic meta_nxt;
    logic q_nxt;

    always_comb begin
        meta_nxt = ce ? d : meta_r;
        q_nxt    = ce ? meta_r : q;
    end

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            q      <= q_nxt;
        end
    end
endmodule // sff_sync
`default_nettype wire

// File: rtl/sff_master.sv
// What this block does
// - four-wire full-duplex spi fetch port
// - port present only when storage option enabled
// - master to one flash, reads only
// - data read with fast read 0x0b
// - enable 32-bit addressing 0xb7 first
// - serial clock is clk divided by two
// - read data sampled two clocks after edge
`default_nettype none
module sff_master
    import sff_pkg::*;
#(
    parameter bit PORT_EN = 1'b1
)(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         ce,
    input  wire logic         srst,
    // fetch request
    input  wire logic         req_valid,
    input  wire sff_req_t     req,
    output var  logic         req_ready,
    // read data stream
    output var  logic         dout_valid,
    output var  logic [7:0]   dout,
    output var  logic         busy,
    output var  sff_spi_out_t spi_o,
    input  wire logic         spi_miso
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    sff_state_t   st_r, st_nxt;
    logic         ph_r, ph_nxt;          // sck phase
    logic [5:0]   cnt_r, cnt_nxt;        // bits left in field
    logic [31:0]  sh_r, sh_nxt;          // outgoing shift
    logic [15:0]  len_r, len_nxt;        // bytes left
    logic         a32_r, a32_nxt;
    logic         a32on_r, a32on_nxt;    // flash already in 32-bit mode
    logic [7:0]   rx_r, rx_nxt;
    logic [2:0]   rxc_r, rxc_nxt;
    logic [1:0]   smp_r, smp_nxt;        // rising-edge launch pipeline
    logic         dv_nxt;
    logic [7:0]   dout_nxt;
    logic         busy_nxt;
    logic         rdy_nxt;
    sff_spi_out_t o_nxt;
    logic         miso_s;
    logic [31:0]  req_addr_r, req_addr_nxt;  // address for the address phase

    sff_sync u_sync (
        .clk  (clk),
        .ce   (ce),
        .srst (srst),
        .d    (spi_miso),
        .q    (miso_s)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt    = st_r;
        ph_nxt    = ph_r;
        cnt_nxt   = cnt_r;
        sh_nxt    = sh_r;
        len_nxt   = len_r;
        a32_nxt   = a32_r;
        a32on_nxt = a32on_r;
        rx_nxt    = rx_r;
        rxc_nxt   = rxc_r;
        smp_nxt   = {smp_r[0], 1'b0};
        dv_nxt    = 1'b0;
        dout_nxt  = dout;
        o_nxt     = spi_o;
        busy_nxt  = (st_r != SFF_IDLE);
        rdy_nxt   = 1'b0;
        // sck toggles each clk while shifting
        if (st_r inside {SFF_EN32, SFF_CMD, SFF_ADDR, SFF_DUMMY, SFF_DATA}) begin
            ph_nxt    = ~ph_r;
            o_nxt.sck = ~ph_r;
        end
        // sample two clocks after rising edge
        if (smp_r[1] && st_r == SFF_DATA) begin
            rx_nxt  = {rx_r[6:0], miso_s};
            rxc_nxt = rxc_r + 3'd1;
            if (rxc_r == 3'd7) begin
                dv_nxt   = 1'b1;
                dout_nxt = {rx_r[6:0], miso_s};
            end
        end
        case (st_r)
            SFF_IDLE: begin
                o_nxt   = '{sck: SFF_SCK_RST, cs_n: SFF_CS_N_RST, mosi: 1'b0};
                ph_nxt  = 1'b0;
                rdy_nxt = PORT_EN && !(req_valid && req_ready);
                if (PORT_EN && req_valid && req_ready && req.len != 16'h0000) begin
                    rdy_nxt  = 1'b0;
                    busy_nxt = 1'b1;
                    // flash left in 32-bit mode wants 32-bit addresses
                    a32_nxt  = req.addr32 || a32on_r;
                    len_nxt  = req.len;
                    o_nxt.cs_n = 1'b0;
                    // switch flash to 32-bit addressing once
                    if (req.addr32 && !a32on_r) begin
                        st_nxt     = SFF_EN32;
                        sh_nxt     = {SFF_CMD_EN_ADDR32, 24'h000000};
                        a32on_nxt  = 1'b1;
                    end else begin
                        st_nxt = SFF_CMD;
                        sh_nxt = {SFF_CMD_FAST_READ, 24'h000000};
                    end
                    o_nxt.mosi = sh_nxt[31];
                    cnt_nxt    = 6'(SFF_CMD_BITS);
                    sh_nxt     = {sh_nxt[30:0], 1'b0};
                    // address held in req_addr_r, loaded into sh after the command
                end
            end
            SFF_GAP: begin
                // cs high for two clocks between commands
                o_nxt.cs_n = ~ph_r ? 1'b1 : 1'b0;
                ph_nxt     = ~ph_r;
                if (ph_r) begin
                    st_nxt     = SFF_CMD;
                    sh_nxt     = {SFF_CMD_FAST_READ, 24'h000000};
                    o_nxt.mosi = SFF_CMD_FAST_READ[7];
                    sh_nxt     = {sh_nxt[30:0], 1'b0};
                    cnt_nxt    = 6'(SFF_CMD_BITS);
                    ph_nxt     = 1'b0;
                end
            end
            SFF_EN32, SFF_CMD, SFF_ADDR, SFF_DUMMY: begin
                // shift msb first on falling edge
                if (ph_r) begin
                    if (cnt_r == 6'd1) begin
                        if (st_r == SFF_EN32) begin
                            st_nxt     = SFF_GAP;
                            o_nxt.cs_n = 1'b1;
                            o_nxt.sck  = 1'b0;
                            ph_nxt     = 1'b0;
                        end else if (st_r == SFF_CMD) begin
                            st_nxt     = SFF_ADDR;
                            cnt_nxt    = a32_r ? 6'(SFF_ADDR32_BITS) : 6'(SFF_ADDR24_BITS);
                            sh_nxt     = a32_r ? req_addr_r : {req_addr_r[23:0], 8'h00};
                            o_nxt.mosi = sh_nxt[31];
                            sh_nxt     = {sh_nxt[30:0], 1'b0};
                        end else if (st_r == SFF_ADDR) begin
                            st_nxt     = SFF_DUMMY;
                            cnt_nxt    = 6'(SFF_DUMMY_BITS);
                            o_nxt.mosi = 1'b0;
                        end else begin
                            st_nxt  = SFF_DATA;
                            rxc_nxt = 3'd0;
                        end
                    end else begin
                        cnt_nxt    = cnt_r - 6'd1;
                        o_nxt.mosi = sh_r[31];
                        sh_nxt     = {sh_r[30:0], 1'b0};
                    end
                end
            end
            SFF_DATA: begin
                if (!ph_r) begin
                    smp_nxt[0] = 1'b1;
                end
                if (dv_nxt) begin
                    len_nxt = len_r - 16'd1;
                    if (len_r == 16'd1) begin
                        st_nxt = SFF_DONE;
                    end
                end
                // stop clocking once the last byte's edges are out
                if (len_r == 16'd1 && rxc_r == 3'd7 && ph_r) begin
                    ph_nxt    = 1'b1;
                    o_nxt.sck = 1'b0;
                end
            end
            default: begin
                o_nxt   = '{sck: SFF_SCK_RST, cs_n: SFF_CS_N_RST, mosi: 1'b0};
                st_nxt  = SFF_IDLE;
                rdy_nxt = PORT_EN;
                busy_nxt = 1'b0;
            end
        endcase
    end

    // 24-bit requests are zero-extended so they also fit a 32-bit mode frame
    always_comb begin
        req_addr_nxt = req_addr_r;
        if (st_r == SFF_IDLE && req_valid && req_ready) begin
            req_addr_nxt = req.addr32 ? req.addr : {8'h00, req.addr[23:0]};
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            st_r       <= SFF_IDLE;
            ph_r       <= 1'b0;
            cnt_r      <= '0;
            sh_r       <= '0;
            len_r      <= '0;
            a32_r      <= 1'b0;
            a32on_r    <= 1'b0;
            rx_r       <= '0;
            rxc_r      <= '0;
            smp_r      <= '0;
            req_addr_r <= '0;
            dout_valid <= 1'b0;
            dout       <= '0;
            busy       <= 1'b0;
            req_ready  <= 1'b0;
            spi_o      <= '{sck: SFF_SCK_RST, cs_n: SFF_CS_N_RST, mosi: 1'b0};
        end else if (ce) begin
            st_r       <= st_nxt;
            ph_r       <= ph_nxt;
            cnt_r      <= cnt_nxt;
            sh_r       <= sh_nxt;
            len_r      <= len_nxt;
            a32_r      <= a32_nxt;
            a32on_r    <= a32on_nxt;
            rx_r       <= rx_nxt;
            rxc_r      <= rxc_nxt;
            smp_r      <= smp_nxt;
            req_addr_r <= req_addr_nxt;
            dout_valid <= dv_nxt;
            dout       <= dout_nxt;
            busy       <= busy_nxt;
            req_ready  <= rdy_nxt;
            spi_o      <= o_nxt;
        end
    end
endmodule // sff_master
`default_nettype wire

// File: test/sff_master_properties.sv
`default_nettype none
module sff_master_properties
    import sff_pkg::*;
#(
    parameter bit PORT_EN = 1'b1
)(
    // clock and reset
    input wire logic         clk,
    input wire logic         ce,
    input wire logic         srst,
    // request and stream
    input wire logic         req_valid,
    input wire sff_req_t     req,
    input wire logic         req_ready,
    input wire logic         dout_valid,
    input wire logic [7:0]   dout,
    input wire logic         busy,
    // pins
    input wire sff_spi_out_t spi_o,
    input wire logic         spi_miso
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ------------------------------------------------------------
    // frame tracking
    // ------------------------------------------------------------
    logic [5:0]  bc_r;
    logic        sck_r;
    logic        cs_r;
    logic        b7_r;
    logic        d32_r;
    logic [15:0] nb_r;
    sff_req_t    rq_r;
    logic        w32_r;
    logic        rise;
    logic        take;
    logic [5:0]  ai;
    logic [7:0]  cmd_w;
    assign rise  = spi_o.sck && !sck_r;
    assign take  = ce && req_valid && req_ready && req.len != 16'h0;
    assign ai    = (w32_r ? 6'd32 : 6'd24) + 6'd7 - bc_r;
    assign cmd_w = b7_r ? SFF_CMD_EN_ADDR32 : SFF_CMD_FAST_READ;
    always_ff @(posedge clk) begin
        sck_r <= spi_o.sck;
        cs_r  <= spi_o.cs_n;
        if (srst) begin
            bc_r  <= 6'h0;
            b7_r  <= 1'b0;
            d32_r <= 1'b0;
            nb_r  <= 16'h0;
            w32_r <= 1'b0;
        end else if (ce) begin
            // saturates so the data phase cannot wrap into command bits
            bc_r <= spi_o.cs_n ? 6'h0 : bc_r + 6'(rise && bc_r != 6'h3f);
            nb_r <= nb_r + 16'(dout_valid);
            if (spi_o.cs_n && !cs_r) b7_r <= 1'b0;
            if (take) begin
                rq_r  <= req;
                // once in 32-bit mode every frame carries a 32-bit address
                if (!req.addr32) rq_r.addr[31:24] <= 8'h00;
                w32_r <= req.addr32 || d32_r;
                nb_r  <= 16'h0;
                b7_r  <= req.addr32 && !d32_r;
                d32_r <= d32_r | req.addr32;
            end
        end
    end
    sequence take_s;
        take;
    endsequence
    idle_sck_a: assert property (spi_o.cs_n |-> !spi_o.sck)
        else $error("sck high while deselected");
    sck_high_a: assert property (ce && spi_o.sck |=> !spi_o.sck)
        else $error("sck high longer than one clock");
    cs_start_a: assert property (take_s |=> !spi_o.cs_n)
        else $error("chip select late after request");
    ready_busy_a: assert property (busy |-> !req_ready)
        else $error("ready while busy");
    cmd_bits_a: assert property (rise && bc_r < 6'd8 |-> spi_o.mosi == cmd_w[3'(7 - bc_r)])
        else $error("command bit wrong");
    addr_bits_a: assert property (rise && !b7_r && bc_r >= 6'd8 && ai < 6'd32 |->
        spi_o.mosi == rq_r.addr[ai[4:0]])
        else $error("address bit wrong");
    en32_len_a: assert property ($rose(spi_o.cs_n) && b7_r |-> bc_r == 6'd8)
        else $error("address mode frame length wrong");
    byte_count_a: assert property ($fell(busy) |-> nb_r + 16'(dout_valid) == rq_r.len)
        else $error("byte count differs from length");
    zero_len_a: assert property (req_valid && req_ready && req.len == 16'h0 |=>
        spi_o.cs_n && !busy)
        else $error("zero length request started");
endmodule // sff_master_properties
bind sff_master sff_master_properties #(.PORT_EN(PORT_EN)) u_sff_master_properties (
    .clk(clk), .ce(ce), .srst(srst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .dout_valid(dout_valid), .dout(dout), .busy(busy),
    .spi_o(spi_o), .spi_miso(spi_miso));
`default_nettype wire

// File: test/sff_flash_model.sv
`default_nettype none
module sff_flash_model
    import sff_pkg::*;
(
    // spi pins
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        mosi,
    output var  logic        miso,
    // observation
    output var  logic [7:0]  cmd_q,
    output var  logic [31:0] addr_q,
    output var  logic        en32_q
);
    timeunit 1ns;
    timeprecision 1ps;
    int         nbit;
    int         alen;
    int         d;
    logic [7:0] sh;
    logic [7:0] dat;
    initial begin
        en32_q = 1'b0;
        miso   = 1'b0;
        nbit   = 0;
    end
    always @(negedge cs_n) begin
        nbit   = 0;
        addr_q = 32'h0;
    end
    always @(posedge sck) if (!cs_n) begin
        alen = en32_q ? 32 : 24;
        sh   = {sh[6:0], mosi};
        nbit++;
        if (nbit == 8) cmd_q = sh;
        if (nbit == 8 && sh == SFF_CMD_EN_ADDR32) en32_q = 1'b1;
        if (nbit > 8 && nbit <= 8 + alen) addr_q = {addr_q[30:0], mosi};
    end
    // data launched on falling sck, byte = address plus offset
    always @(negedge sck) if (!cs_n && cmd_q == SFF_CMD_FAST_READ && nbit >= 16 + alen) begin
        d    = nbit - 16 - alen;
        dat  = addr_q[7:0] + 8'(d / 8);
        miso = dat[7 - d % 8];
    end
    // released line: no pull, so show the inverse
    always @(posedge cs_n) miso = ~miso;
endmodule // sff_flash_model
`default_nettype wire

// File: test/tb_top.sv
`default_nettype none
module tb_top
    import sff_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk = 1'b0;
    logic         srst = 1'b1;
    logic         ce = 1'b1;
    logic         req_valid = 1'b0;
    sff_req_t     req = '0;
    logic         req_ready;
    logic         dout_valid;
    logic [7:0]   dout;
    logic         busy;
    sff_spi_out_t spi_o;
    logic         spi_miso;
    logic [7:0]   cmd_q;
    logic [31:0]  addr_q;
    logic         en32_q;
    int           n_mismatch = 0;
    int           tests_run = 0;
    always #2.5 clk = ~clk;
    sff_master u_sff_master (.clk(clk), .ce(ce), .srst(srst), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .dout_valid(dout_valid), .dout(dout),
        .busy(busy), .spi_o(spi_o), .spi_miso(spi_miso));
    sff_flash_model u_sff_flash_model (.sck(spi_o.sck), .cs_n(spi_o.cs_n),
        .mosi(spi_o.mosi), .miso(spi_miso), .cmd_q(cmd_q), .addr_q(addr_q), .en32_q(en32_q));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic do_read(input logic a32, input logic [31:0] ad, input logic [15:0] n);
        int k;
        int w;
        k = 0;
        w = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req       <= '{a32, ad, n};
        do begin
            @(posedge clk);
            w++;
        end while (req_ready !== 1'b1 && w < 2000);
        req_valid <= 1'b0;
        while ((k < n || busy !== 1'b0) && w < 4000) begin
            @(posedge clk);
            w++;
            if (dout_valid === 1'b1) begin
                chk("dout", 8'(ad[7:0] + k), dout);
                k++;
            end
        end
        chk("bytes", n, k);
        if (w >= 4000) begin
            n_mismatch++;
            $display("[FAIL] cycles exp below %0d got %0d", 4000, w);
            end_of_test();
        end
        chk("cmd", SFF_CMD_FAST_READ, cmd_q);
        chk("addr", a32 ? ad : {8'h0, ad[23:0]}, addr_q);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        repeat (20) @(posedge clk);
        chk("ready_rst", 0, req_ready);
        chk("cs_rst", 1, spi_o.cs_n);
        chk("sck_rst", 0, spi_o.sck);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("ready", 1, req_ready);
        $display("t_reset done");
    endtask
    task automatic t_freeze();
        ce        <= 1'b0;
        req_valid <= 1'b1;
        req       <= '{1'b0, 32'h0000_0040, 16'h1};
        repeat (6) @(posedge clk) chk("cs_freeze", 1, spi_o.cs_n);
        req_valid <= 1'b0;
        ce        <= 1'b1;
        @(posedge clk);
        chk("ready_freeze", 1, req_ready);
        $display("t_freeze done");
    endtask
    task automatic t_rd24(input logic e32);
        do_read(1'b0, 32'h00c3_a5fe, 16'h3);
        chk("en32", e32, en32_q);
        $display("t_rd24 done");
    endtask
    task automatic t_zero();
        req_valid <= 1'b1;
        req       <= '{1'b0, 32'h0000_0010, 16'h0};
        repeat (8) @(posedge clk) chk("cs_zero", 1, spi_o.cs_n);
        req_valid <= 1'b0;
        $display("t_zero done");
    endtask
    task automatic t_rd32();
        do_read(1'b1, 32'h8a5c_31ff, 16'h2);
        chk("en32", 1, en32_q);
        do_read(1'b1, 32'hf000_0080, 16'h1);
        $display("t_rd32 done");
    endtask
    initial begin
        t_reset();
        t_freeze();
        t_rd24(1'b0);
        t_zero();
        t_rd32();
        t_rd24(1'b1);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
